// >>> src/slc_link_cfg.sv
// servo link mode configuration and combination checker with apb registers
`timescale 1ns/1ps
module slc_link_cfg #(
  parameter int UNIT_CLKS = slc_pkg::UNIT_CLKS, // clocks per 62.5 us unit
  parameter bit STANDARD_VARIANT = 1'b0 // standard type: no full-closed option
)
(
  input logic clk,
  input logic rst_b,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic cmd_valid,
  input slc_pkg::slc_cmd_t cmd_type,
  output logic cmd_error,
  output logic cmd_applied,
  output slc_pkg::slc_cmd_t active_cmd,
  output logic comm_tick,
  output logic update_tick,
  output logic param_combo_error,
  output logic axis_limit_error,
  output logic frame_32byte,
  output logic interaxis_full_sync,
  output logic ext_monitor_en,
  output logic full_closed
);
  import slc_pkg::*;
  generate
    if (UNIT_CLKS < 2 || UNIT_CLKS > 1048575)
    begin : g_bad_unit
      $error("slc_link_cfg: UNIT_CLKS out of range");
    end
  endgenerate
  // software-visible settings
  logic [2:0] control_mode_select_ff;
  logic [7:0] link_cycle_code_ff;
  logic [1:0] update_ratio_setting_ff;
  logic [15:0] link_expansion_word_ff;
  logic [20:0] link_cycle_ns_value_ff;
  logic [5:0] axis_count_ff;
  // apb answer flops
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  // status and link-facing flops
  logic param_err_ff;
  logic axis_err_ff;
  logic cmd_error_ff;
  logic cmd_applied_ff;
  slc_cmd_t active_ff;
  logic pend_ff; // a command waits for its cycle
  slc_cmd_t pend_type_ff;
  logic frame32_ff;
  logic sync_ff;
  logic monitor_ff;
  logic full_ff;
  // combinational helpers
  logic apb_access;
  logic apb_first;
  logic addr_ok;
  logic wr_bad;
  logic wr_en;
  logic cfg_wr;
  logic mode_legal;
  logic [31:0] nxt_prdata;
  logic [5:0] eff_units;
  logic cycle_ok;
  logic ratio_ok;
  logic [5:0] axis_lim;
  logic is_full;
  logic is_32;
  logic vel_or_torque;
  logic cmd_bad;
  logic apply_now;
  logic unit_tick;
  logic comm_tick_w;
  logic update_tick_w;
  logic [15:0] status;

  // first access cycle starts the answer; done when pready is seen
  assign apb_access = psel & penable;
  assign apb_first = apb_access & ~pready_ff;
  // write commits only at the edge the master samples pready
  assign wr_en = apb_access & pready_ff & pwrite & ~pslverr_ff;
  // a cycle setting change realigns the cycle dividers
  assign cfg_wr = wr_en & ((paddr == ADDR_CODE) | (paddr == ADDR_NS) | (paddr == ADDR_RATIO));

  // reserved modes are refused; full-closed absent on standard type
  assign mode_legal = (pwdata[31:3] == 29'h0) &&
    ((pwdata[2:0] == MODE_SEMI) || (pwdata[2:0] == MODE_FULL && !STANDARD_VARIANT));

  assign status = {1'b0, full_ff, eff_units, active_ff, monitor_ff, sync_ff, frame32_ff,
    cmd_error_ff, axis_err_ff, param_err_ff};

  // address decode and read mux
  always_comb
  begin
    nxt_prdata = 32'h0;
    addr_ok = 1'b1;
    wr_bad = 1'b0;
    case (paddr)
      ADDR_MODE:
      begin
        nxt_prdata = {29'h0, control_mode_select_ff};
        wr_bad = pwrite & ~mode_legal;
      end
      ADDR_CODE: nxt_prdata = {24'h0, link_cycle_code_ff};
      ADDR_RATIO: nxt_prdata = {30'h0, update_ratio_setting_ff};
      ADDR_EXP: nxt_prdata = {16'h0, link_expansion_word_ff};
      ADDR_NS: nxt_prdata = {11'h0, link_cycle_ns_value_ff};
      ADDR_AXIS: nxt_prdata = {26'h0, axis_count_ff};
      ADDR_STATUS: nxt_prdata = {16'h0, status};
      default: addr_ok = 1'b0; // unmapped: error, reads zero
    endcase
  end

  // apb answer: pready one cycle into the access phase
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      pready_ff <= apb_first;
      pslverr_ff <= apb_first & (~addr_ok | wr_bad);
      prdata_ff <= (apb_first & ~pwrite & addr_ok) ? nxt_prdata : 32'h0;
    end
  end

  // setting registers, written only by an accepted apb write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      control_mode_select_ff <= RST_MODE;
      link_cycle_code_ff <= RST_CODE;
      update_ratio_setting_ff <= RST_RATIO;
      link_expansion_word_ff <= RST_EXP;
      link_cycle_ns_value_ff <= RST_NS;
      axis_count_ff <= RST_AXIS;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_MODE: control_mode_select_ff <= pwdata[2:0];
        ADDR_CODE: link_cycle_code_ff <= pwdata[7:0];
        ADDR_RATIO: update_ratio_setting_ff <= pwdata[1:0];
        ADDR_EXP: link_expansion_word_ff <= pwdata[15:0];
        ADDR_NS: link_cycle_ns_value_ff <= pwdata[20:0];
        ADDR_AXIS: axis_count_ff <= pwdata[5:0];
        default: ; // status is read-only
      endcase
    end
  end

  // effective cycle; ns value counts only behind code -1
  always_comb
  begin
    eff_units = 6'h00;
    if (link_cycle_code_ff == CODE_500US)
      eff_units = U_500US;
    else if (link_cycle_code_ff == CODE_1MS)
      eff_units = U_1MS;
    else if (link_cycle_code_ff == CODE_NS)
    begin
      case (link_cycle_ns_value_ff)
        NS_62500: eff_units = U_62500;
        NS_125000: eff_units = U_125000;
        NS_250000: eff_units = U_250000;
        NS_500000: eff_units = U_500US;
        NS_1000000: eff_units = U_1MS;
        NS_2000000: eff_units = U_2MS;
        default: eff_units = 6'h00;
      endcase
    end
  end

  // reserved codes or bad ns leave eff_units at zero
  assign cycle_ok = (eff_units != 6'h00);
  assign ratio_ok = (update_ratio_setting_ff == RATIO_1) || (update_ratio_setting_ff == RATIO_2);
  assign is_full = (control_mode_select_ff == MODE_FULL);
  assign is_32 = link_expansion_word_ff[EXP_SIZE_BIT];

  // axis limit by cycle, halved in 32-byte mode
  always_comb
  begin
    case (eff_units)
      U_62500: axis_lim = AXIS_LIM_62500;
      U_125000: axis_lim = AXIS_LIM_125000;
      U_250000: axis_lim = AXIS_LIM_250000;
      default: axis_lim = AXIS_LIM_SLOW;
    endcase
    if (is_32)
      axis_lim = axis_lim >> 1;
  end

  // status and configuration outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      param_err_ff <= 1'b0;
      axis_err_ff <= 1'b0;
      frame32_ff <= 1'b0;
      sync_ff <= 1'b0;
      monitor_ff <= 1'b0;
      full_ff <= 1'b0;
    end
    else
    begin
      param_err_ff <= ~cycle_ok | ~ratio_ok;
      axis_err_ff <= cycle_ok & (axis_count_ff > axis_lim);
      frame32_ff <= is_32;
      sync_ff <= link_expansion_word_ff[EXP_SYNC_BIT];
      // full-closed always monitors; semi only off the standard type
      monitor_ff <= is_full |
        (link_expansion_word_ff[EXP_MON_BIT] & ~STANDARD_VARIANT);
      full_ff <= is_full;
    end
  end

  // base unit tick from the system clock
  slc_pulse_div #(.WIDTH(20)) u_unit_div (
    .clk(clk),
    .rst_b(rst_b),
    .en(1'b1),
    .restart(1'b0),
    .len(20'(UNIT_CLKS)),
    .tick(unit_tick)
  );

  // communication cycle, silent while settings are bad
  slc_pulse_div #(.WIDTH(6)) u_comm_div (
    .clk(clk),
    .rst_b(rst_b),
    .en(unit_tick & ~param_err_ff),
    .restart(cfg_wr),
    .len(eff_units),
    .tick(comm_tick_w)
  );

  // command updating cycle: ratio communication cycles
  slc_pulse_div #(.WIDTH(2)) u_update_div (
    .clk(clk),
    .rst_b(rst_b),
    .en(comm_tick_w),
    .restart(cfg_wr),
    .len(update_ratio_setting_ff),
    .tick(update_tick_w)
  );

  // command acceptance against mode and frame size
  assign vel_or_torque = (cmd_type == cyclic_velocity_cmd) || (cmd_type == cyclic_torque_cmd);
  assign cmd_bad = param_err_ff |
    (is_full & vel_or_torque) |
    (is_32 & (eff_units < U_500US)) |
    (is_32 & vel_or_torque);
  // cyclic position waits for the update cycle, others any cycle
  assign apply_now = pend_ff &
    ((pend_type_ff == cyclic_position_cmd) ? update_tick_w : comm_tick_w);

  // command error reflects the latest command offered
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cmd_error_ff <= 1'b0;
    else if (cmd_valid)
      cmd_error_ff <= cmd_bad;
  end

  // pending command; a new one in the apply cycle is kept
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_ff <= 1'b0;
      pend_type_ff <= profile_position_cmd;
    end
    else if (cmd_valid && !cmd_bad)
    begin
      pend_ff <= 1'b1;
      pend_type_ff <= cmd_type;
    end
    else if (apply_now)
      pend_ff <= 1'b0;
  end

  // active command switches only on its cycle tick
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active_ff <= profile_position_cmd;
      cmd_applied_ff <= 1'b0;
    end
    else
    begin
      cmd_applied_ff <= apply_now;
      if (apply_now)
        active_ff <= pend_type_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cmd_error = cmd_error_ff;
  assign cmd_applied = cmd_applied_ff;
  assign active_cmd = active_ff;
  assign comm_tick = comm_tick_w;
  assign update_tick = update_tick_w;
  assign param_combo_error = param_err_ff;
  assign axis_limit_error = axis_err_ff;
  assign frame_32byte = frame32_ff;
  assign interaxis_full_sync = sync_ff;
  assign ext_monitor_en = monitor_ff;
  assign full_closed = full_ff;
  // mode register never holds a reserved value
  a_mode_legal_value: assert property (@(posedge clk) disable iff (!rst_b)
    (control_mode_select_ff == MODE_SEMI) ||
    (control_mode_select_ff == MODE_FULL && !STANDARD_VARIANT))
    else $error("mode register holds a refused value");
  // refused command leaves the pending type alone
  a_full_refuse_vt: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && is_full && vel_or_torque |=> $stable(pend_type_ff) && cmd_error_ff)
    else $error("velocity or torque accepted in full-closed");
  // the 1 ms fixed code ignores the ns value
  a_code_ignores_ns: assert property (@(posedge clk) disable iff (!rst_b)
    (link_cycle_code_ff == CODE_1MS) && ratio_ok |=> !param_combo_error)
    else $error("setup error with fixed code and good ratio");
  // unlisted ns value behind code -1 is an error
  a_ns_value_check: assert property (@(posedge clk) disable iff (!rst_b)
    (link_cycle_code_ff == CODE_NS) && (link_cycle_ns_value_ff == NS_62500 + 21'h1)
    |=> param_combo_error)
    else $error("bad ns value not flagged");
  // size bit reaches the frame size output one cycle later
  a_size_bit_out: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 frame_32byte == $past(link_expansion_word_ff[0]))
    else $error("frame size does not follow expansion bit 0");
  // full-closed always monitors the scale
  a_full_monitor_on: assert property (@(posedge clk) disable iff (!rst_b)
    is_full ##1 is_full |-> ext_monitor_en)
    else $error("scale monitor off in full-closed");
  // 32-byte fast cycles refuse every command
  a_fast_32_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && is_32 && cycle_ok && (eff_units < U_500US) |=> cmd_error_ff)
    else $error("command accepted in 32-byte fast cycle");
  // cyclic position is applied only right after an update tick
  a_cp_on_update: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_applied && active_cmd == cyclic_position_cmd |-> $past(update_tick_w))
    else $error("cyclic position applied off the update cycle");
  // 32-byte at the fastest cycle allows two axes
  a_axis_32_fast: assert property (@(posedge clk) disable iff (!rst_b)
    is_32 && eff_units == U_62500 && axis_count_ff == 6'h03 |=> axis_limit_error)
    else $error("axis limit not flagged");
  // apb answers exactly one cycle into the access phase
  a_apb_one_wait: assert property (@(posedge clk) disable iff (!rst_b)
    apb_first |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule

// >>> src/slc_pkg.sv
// shared constants and types of the servo link mode configuration checker
package slc_pkg;
  // apb register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CODE = 8'h04;
  localparam logic [7:0] ADDR_RATIO = 8'h08;
  localparam logic [7:0] ADDR_EXP = 8'h0c;
  localparam logic [7:0] ADDR_NS = 8'h10;
  localparam logic [7:0] ADDR_AXIS = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // control mode values
  localparam logic [2:0] MODE_SEMI = 3'h0;
  localparam logic [2:0] MODE_FULL = 3'h6;
  // cycle codes, 8-bit two's complement
  localparam logic [7:0] CODE_500US = 8'h03;
  localparam logic [7:0] CODE_1MS = 8'h06;
  localparam logic [7:0] CODE_NS = 8'hff;
  // update ratios
  localparam logic [1:0] RATIO_1 = 2'h1;
  localparam logic [1:0] RATIO_2 = 2'h2;
  // legal expansion cycle values in ns
  localparam logic [20:0] NS_62500 = 21'h00f424;
  localparam logic [20:0] NS_125000 = 21'h01e848;
  localparam logic [20:0] NS_250000 = 21'h03d090;
  localparam logic [20:0] NS_500000 = 21'h07a120;
  localparam logic [20:0] NS_1000000 = 21'h0f4240;
  localparam logic [20:0] NS_2000000 = 21'h1e8480;
  // cycle lengths in 62.5 us base units
  localparam logic [5:0] U_62500 = 6'h01;
  localparam logic [5:0] U_125000 = 6'h02;
  localparam logic [5:0] U_250000 = 6'h04;
  localparam logic [5:0] U_500US = 6'h08;
  localparam logic [5:0] U_1MS = 6'h10;
  localparam logic [5:0] U_2MS = 6'h20;
  // 16-byte axis limits; 32-byte halves them
  localparam logic [5:0] AXIS_LIM_62500 = 6'h04;
  localparam logic [5:0] AXIS_LIM_125000 = 6'h08;
  localparam logic [5:0] AXIS_LIM_250000 = 6'h10;
  localparam logic [5:0] AXIS_LIM_SLOW = 6'h20;
  // expansion word bit positions
  localparam int EXP_SIZE_BIT = 0;
  localparam int EXP_SYNC_BIT = 1;
  localparam int EXP_MON_BIT = 4;
  // values after reset
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [7:0] RST_CODE = 8'h03;
  localparam logic [1:0] RST_RATIO = 2'h1;
  localparam logic [15:0] RST_EXP = 16'h0000;
  localparam logic [20:0] RST_NS = 21'h07a120;
  localparam logic [5:0] RST_AXIS = 6'h01;
  // base time unit and clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_NS = 62500;
  localparam int UNIT_CLKS = UNIT_NS / CLK_PERIOD_NS;
  // command types on the cyclic link
  typedef enum logic [1:0] {
    profile_position_cmd,
    cyclic_position_cmd,
    cyclic_velocity_cmd,
    cyclic_torque_cmd
  } slc_cmd_t;
endpackage

// >>> src/slc_pulse_div.sv
// pulse divider: one tick every len enable pulses
`timescale 1ns/1ps
module slc_pulse_div #(
  parameter int WIDTH = 8 // width of the length and the counter
)
(
  input logic clk,
  input logic rst_b,
  input logic en,
  input logic restart,
  input logic [WIDTH-1:0] len,
  output logic tick
);
  logic [WIDTH-1:0] cnt_ff; // enable pulses seen in this period
  logic tick_ff; // one-cycle tick
  logic wrap; // last pulse of the period

  generate
    if (WIDTH < 1 || WIDTH > 31)
    begin : g_bad_width
      $error("slc_pulse_div: WIDTH out of range");
    end
  endgenerate

  // a zero length never wraps, so no ticks come out
  assign wrap = (len != '0) && (cnt_ff >= WIDTH'(len - 1'b1));

  // period counter, restarted on a config change
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (restart)
      cnt_ff <= '0;
    else if (en)
      cnt_ff <= wrap ? '0 : WIDTH'(cnt_ff + 1'b1);
  end

  // tick flop, so the output is clean
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tick_ff <= 1'b0;
    else
      tick_ff <= en & ~restart & wrap;
  end

  assign tick = tick_ff;
endmodule

// >>> test/slc_host_model.sv
// host motion controller model that offers commands on the cyclic link
`timescale 1ns/1ps
module slc_host_model
(
  input logic clk,
  input logic rst_b,
  input logic req, // one-cycle request from the bench
  input slc_pkg::slc_cmd_t req_type, // command type to offer
  input logic slow, // wait for the next cycle boundary before offering
  input logic comm_tick, // cycle boundary seen from the driver
  output logic cmd_valid,
  output slc_pkg::slc_cmd_t cmd_type
);
  import slc_pkg::*;
  logic pend_ff; // a request still waiting to go out
  slc_cmd_t type_ff; // type held while pending
  logic go; // offer in this cycle
  assign go = pend_ff && (!slow || comm_tick);
  // the host keeps no cycle settings of its own; it takes the boundary from
  // the driver's comm_tick, and a slow offer goes out the cycle after that tick
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_ff <= 1'b0;
      type_ff <= profile_position_cmd;
    end
    else if (req)
    begin
      pend_ff <= 1'b1;
      type_ff <= req_type;
    end
    else if (go)
      pend_ff <= 1'b0;
  end
  // one-cycle offer; between offers the type wobbles so no stale value looks valid
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_valid <= 1'b0;
      cmd_type <= profile_position_cmd;
    end
    else if (go)
    begin
      cmd_valid <= 1'b1;
      cmd_type <= type_ff;
    end
    else
    begin
      cmd_valid <= 1'b0;
      cmd_type <= slc_cmd_t'(~cmd_type);
    end
  end
endmodule

// >>> test/slc_link_cfg_tb_top.sv
// self-checking bench for the link configuration checker
`timescale 1ns/1ps
module slc_link_cfg_tb_top;
  import slc_pkg::*;
  localparam int UC = 20; // short unit keeps cycles brief
  localparam logic [31:0] RSTV [7] = '{32'h0, 32'h3, 32'h1, 32'h0, 32'h7a120, 32'h1, 32'h800};
  localparam logic [7:0] CODES [10] = '{8'h03, 8'h06, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h05};
  localparam logic [20:0] NSV [10] = '{21'h186a0, 21'h186a0, NS_62500, NS_125000, NS_250000, NS_500000,
    NS_1000000, NS_2000000, 21'h00f425, NS_500000};
  localparam int UNITS [10] = '{8, 16, 1, 2, 4, 8, 16, 32, 0, 0}; // 0 marks an illegal setting
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic req, slow, cmd_valid, cmd_error, cmd_applied, comm_tick, update_tick;
  logic param_combo_error, axis_limit_error, frame_32byte, interaxis_full_sync, ext_monitor_en, full_closed;
  slc_cmd_t cmd_type, active_cmd, req_type;
  logic pslverr_s, perr_s, ext_monitor_en_s, full_closed_s; // standard variant copy
  int err_total, n_compared, gap;

  slc_link_cfg #(.UNIT_CLKS(UC)) i_slc_link_cfg (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cmd_valid, .cmd_type, .cmd_error, .cmd_applied, .active_cmd, .comm_tick, .update_tick,
    .param_combo_error, .axis_limit_error, .frame_32byte, .interaxis_full_sync, .ext_monitor_en,
    .full_closed);
  slc_host_model i_slc_host_model (.clk, .rst_b, .req, .req_type, .slow, .comm_tick, .cmd_valid, .cmd_type);
  // standard variant on the same bus: no full-closed, no semi-closed scale monitor
  slc_link_cfg #(.UNIT_CLKS(UC), .STANDARD_VARIANT(1'b1)) i_slc_link_cfg_std (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(pslverr_s),
    .cmd_valid, .cmd_type, .cmd_error(), .cmd_applied(), .active_cmd(), .comm_tick(), .update_tick(),
    .param_combo_error(), .axis_limit_error(), .frame_32byte(), .interaxis_full_sync(),
    .ext_monitor_en(ext_monitor_en_s), .full_closed(full_closed_s));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic nap(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      err_total++; // no answer within the limit
    rd = prdata;
    perr = pslverr;
    perr_s = pslverr_s;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write, then let outputs follow the new setting
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    nap(2);
  endtask

  task automatic rst_vals();
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, RSTV[i]);
    end
  endtask

  // ask the host for a command and check the refusal flag
  task automatic cmd(input slc_cmd_t t, input logic e);
    int n;
    @(posedge clk);
    req <= 1'b1;
    req_type <= t;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cmd_valid !== 1'b1 && n < 2000);
    if (cmd_valid !== 1'b1)
      err_total++; // host never offered
    @(posedge clk);
    chk(cmd_error, e);
  endtask

  // wait for the apply pulse; the right tick must come one cycle before it
  task automatic applied(input slc_cmd_t t, input logic upd);
    logic pt;
    int n;
    pt = 1'b0;
    n = 0;
    while (cmd_applied !== 1'b1 && n < 3000)
    begin
      pt = upd ? update_tick : comm_tick;
      @(posedge clk);
      n++;
    end
    if (cmd_applied !== 1'b1)
      err_total++; // never applied
    chk(active_cmd, t);
    chk(pt, 1'b1);
  endtask

  // clocks between two ticks of one kind
  task automatic tick_gap(input logic u, output int g);
    int n;
    n = 0;
    while ((u ? update_tick : comm_tick) !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    g = 0;
    do
    begin
      @(posedge clk);
      g++;
    end
    while ((u ? update_tick : comm_tick) !== 1'b1 && g < 2000);
  endtask

  task automatic ax(input logic [31:0] n, input logic e);
    wr(ADDR_AXIS, n);
    chk(axis_limit_error, e);
  endtask

  // watchdog, well beyond the expected run
  initial
  begin
    nap(40000);
    err_total++;
    results();
  end

  initial
  begin
    {rst_b, psel, penable, pwrite, req, slow} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    req_type = profile_position_cmd;
    err_total = 0;
    n_compared = 0;
    nap(4);
    rst_b <= 1'b1;
    rst_vals();
    apb(1'b0, 8'h1c, 32'h0);
    chk(perr, 1'b1);
    chk(rd, 32'h0);
    // every reserved mode is refused and leaves mode 0 in place
    for (int m = 1; m < 8; m++)
      if (m != 6)
      begin
        wr(ADDR_MODE, 32'(m));
        chk(perr, 1'b1);
      end
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rd, 32'h0);
    wr(ADDR_MODE, 32'h6);
    chk(perr_s, 1'b1);
    chk(full_closed_s, 1'b0);
    chk(full_closed, 1'b1);
    chk(ext_monitor_en, 1'b1);
    cmd(cyclic_velocity_cmd, 1'b1);
    cmd(cyclic_torque_cmd, 1'b1);
    cmd(profile_position_cmd, 1'b0);
    applied(profile_position_cmd, 1'b0);
    wr(ADDR_MODE, 32'h0);
    chk(ext_monitor_en, 1'b0);
    // every cycle code and period, illegal ns ignored unless code is -1
    for (int i = 0; i < 10; i++)
    begin
      wr(ADDR_NS, 32'(NSV[i]));
      wr(ADDR_CODE, 32'(CODES[i]));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({26'h0, rd[13:8]}, UNITS[i]);
      chk(param_combo_error, UNITS[i] == 0);
      if (UNITS[i] != 0)
      begin
        tick_gap(1'b0, gap);
        chk(gap, UNITS[i] * UC);
      end
    end
    wr(ADDR_CODE, 32'h3);
    chk(param_combo_error, 1'b0);
    wr(ADDR_RATIO, 32'h0);
    chk(param_combo_error, 1'b1);
    wr(ADDR_RATIO, 32'h3);
    chk(param_combo_error, 1'b1);
    wr(ADDR_RATIO, 32'h2);
    chk(param_combo_error, 1'b0);
    tick_gap(1'b1, gap);
    chk(gap, 2 * 8 * UC);
    // 32-byte frames at 500 us: position types only
    wr(ADDR_EXP, 32'h1);
    chk(frame_32byte, 1'b1);
    cmd(cyclic_velocity_cmd, 1'b1);
    cmd(cyclic_torque_cmd, 1'b1);
    slow <= 1'b1;
    cmd(cyclic_position_cmd, 1'b0);
    applied(cyclic_position_cmd, 1'b1);
    slow <= 1'b0;
    ax(32'd16, 1'b0);
    ax(32'd17, 1'b1);
    wr(ADDR_CODE, 32'hff);
    wr(ADDR_NS, 32'(NS_250000));
    cmd(cyclic_position_cmd, 1'b1);
    ax(32'd8, 1'b0);
    ax(32'd9, 1'b1);
    wr(ADDR_NS, 32'(NS_62500));
    ax(32'd2, 1'b0);
    ax(32'd3, 1'b1);
    wr(ADDR_NS, 32'(NS_250000));
    wr(ADDR_EXP, 32'h0);
    ax(32'd16, 1'b0);
    ax(32'd17, 1'b1);
    wr(ADDR_NS, 32'(NS_1000000));
    ax(32'd32, 1'b0);
    ax(32'd33, 1'b1);
    wr(ADDR_EXP, 32'h2);
    chk(interaxis_full_sync, 1'b1);
    chk(frame_32byte, 1'b0);
    wr(ADDR_EXP, 32'h10);
    chk(ext_monitor_en_s, 1'b0);
    chk(ext_monitor_en, 1'b1);
    chk(interaxis_full_sync, 1'b0);
    // second reset in mid-run brings every setting back
    @(posedge clk);
    rst_b <= 1'b0;
    nap(2);
    rst_b <= 1'b1;
    rst_vals();
    chk(active_cmd, profile_position_cmd);
    results();
  end
endmodule
